// >>> inc/rscc_pkg.sv
// package: strap field layout, defaults and register map of the strap loader
package rscc_pkg;
  // pin field positions on the narrow interface address bus (bits 20:1)
  localparam int ADDR_LSB = 1;
  localparam int ADDR_MSB = 20;
  localparam int ENDIAN_BIT = 20;
  localparam int BOOT_MSB = 19;
  localparam int BOOT_LSB = 18;
  localparam int WIDE_CLK_MSB = 17;
  localparam int WIDE_CLK_LSB = 16;
  localparam int NARROW_CLK_MSB = 15;
  localparam int NARROW_CLK_LSB = 14;
  localparam int AUTOINIT_BIT = 13;
  localparam int CELL_PORT_BIT = 11;

  typedef enum logic [1:0] {
    RSCC_BOOT_NONE = 2'b00,
    RSCC_BOOT_HOST_PORT = 2'b01,
    RSCC_BOOT_ROM8 = 2'b10,
    RSCC_BOOT_RSVD = 2'b11
  } rscc_boot_e;

  typedef enum logic [1:0] {
    RSCC_CLK_EXT_PIN = 2'b00,
    RSCC_CLK_CPU_DIV4 = 2'b01,
    RSCC_CLK_CPU_DIV6 = 2'b10,
    RSCC_CLK_RSVD = 2'b11
  } rscc_clk_e;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_DRIVE_BIT = 0;
  // config register layout
  localparam int CFG_ENDIAN_BIT = 0;
  localparam int CFG_BOOT_LSB = 1;
  localparam int CFG_WIDE_CLK_LSB = 3;
  localparam int CFG_NARROW_CLK_LSB = 5;
  localparam int CFG_AUTOINIT_BIT = 7;
  localparam int CFG_CELL_PORT_BIT = 8;
  localparam int CFG_SERIAL_BIT = 9;
endpackage

// >>> rtl/rscc_pin_sync.sv
// module: three-stage pin synchroniser with agreement filter, one per bit
`timescale 1ns/100ps
module rscc_pin_sync #(
  parameter int WIDTH = 20
) (
  // clock
  input wire logic clk,
  // pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_stable
);
  if (WIDTH < 1) begin : g_chk
    $error("rscc_pin_sync: WIDTH must be at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic st_reg;
    logic st_next;
    always_comb begin
      // first stage feeds only the second
      st_next = (s2_reg == s3_reg) ? s3_reg : st_reg;
    end
    // no reset: the chain must keep sampling straps while reset is held
    always_ff @(posedge clk) begin
      s1_reg <= pin_in[i];
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      st_reg <= st_next;
    end
    assign pin_stable[i] = st_reg;
  end
endmodule // rscc_pin_sync

// >>> rtl/rscc_strap_loader.sv
// module: reset strap capture on narrow interface address pins, AHB-Lite regs
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module rscc_strap_loader (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // address source from the memory controller
  input wire logic [rscc_pkg::ADDR_MSB:rscc_pkg::ADDR_LSB] mem_addr,
  input wire logic mem_addr_drive,
  // narrow interface address pins
  input wire logic [rscc_pkg::ADDR_MSB:rscc_pkg::ADDR_LSB]
    narrow_if_addr_pins_i,
  output logic [rscc_pkg::ADDR_MSB:rscc_pkg::ADDR_LSB]
    narrow_if_addr_pins_o,
  output logic narrow_if_addr_pins_oe,
  // captured configuration
  output logic little_endian,
  output logic [1:0] boot_mode,
  output logic [1:0] wide_if_clock_select,
  output logic [1:0] narrow_if_clock_select,
  output logic pci_eeprom_autoinit,
  output logic cell_port_enable,
  output logic serial_port_one_enable
);
  localparam int AW = rscc_pkg::ADDR_MSB - rscc_pkg::ADDR_LSB + 1;

  // the field map must sit inside the pin range, and pins and register
  // fields inside the bus word, or the selects reach past their vectors
  if (rscc_pkg::ENDIAN_BIT > rscc_pkg::ADDR_MSB ||
      rscc_pkg::CELL_PORT_BIT < rscc_pkg::ADDR_LSB) begin : g_chk_pins
    $error("rscc_strap_loader: strap field outside the pin range");
  end
  if (rscc_pkg::CFG_SERIAL_BIT > 31 ||
      rscc_pkg::CTRL_DRIVE_BIT > 31) begin : g_chk_word
    $error("rscc_strap_loader: register field beyond the bus word");
  end
  if (rscc_pkg::ADDR_MSB > 31 || rscc_pkg::ADDR_LSB < 1) begin : g_chk_addr
    $error("rscc_strap_loader: pin range does not fit the read word");
  end

  logic [AW-1:0] pins_stable;
  logic [rscc_pkg::ADDR_MSB:rscc_pkg::ADDR_LSB] straps;

  rscc_pin_sync #(
    .WIDTH(AW)
  ) u_sync (
    .clk(clk),
    .pin_in(narrow_if_addr_pins_i),
    .pin_stable(pins_stable)
  );
  assign straps = pins_stable;

  // ---------------- strap capture ----------------
  logic endian_reg, endian_next;
  logic [1:0] boot_reg, boot_next;
  logic [1:0] wclk_reg, wclk_next;
  logic [1:0] nclk_reg, nclk_next;
  logic ainit_reg, ainit_next;
  logic cell_reg, cell_next;
  logic serial_reg, serial_next;

  always_comb begin
    endian_next = endian_reg;
    boot_next = boot_reg;
    wclk_next = wclk_reg;
    nclk_next = nclk_reg;
    ainit_next = ainit_reg;
    cell_next = cell_reg;
    serial_next = serial_reg;
    // sampled only while reset is held; frozen from release on
    // reserved codes are kept as captured; nothing maps them to a default
    if (sys_rst) begin
      endian_next = straps[rscc_pkg::ENDIAN_BIT];
      boot_next = straps[rscc_pkg::BOOT_MSB:rscc_pkg::BOOT_LSB];
      wclk_next = straps[rscc_pkg::WIDE_CLK_MSB:rscc_pkg::WIDE_CLK_LSB];
      nclk_next =
        straps[rscc_pkg::NARROW_CLK_MSB:rscc_pkg::NARROW_CLK_LSB];
      ainit_next = straps[rscc_pkg::AUTOINIT_BIT];
      cell_next = straps[rscc_pkg::CELL_PORT_BIT];
      serial_next = ~straps[rscc_pkg::CELL_PORT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    endian_reg <= endian_next;
    boot_reg <= boot_next;
    wclk_reg <= wclk_next;
    nclk_reg <= nclk_next;
    ainit_reg <= ainit_next;
    cell_reg <= cell_next;
    serial_reg <= serial_next;
  end

  assign little_endian = endian_reg;
  assign boot_mode = boot_reg;
  assign wide_if_clock_select = wclk_reg;
  assign narrow_if_clock_select = nclk_reg;
  assign pci_eeprom_autoinit = ainit_reg;
  assign cell_port_enable = cell_reg;
  assign serial_port_one_enable = serial_reg;

  // ---------------- address pin drive ----------------
  logic [AW-1:0] pin_out_reg, pin_out_next;
  logic pin_oe_reg, pin_oe_next;
  logic [31:0] ctrl_reg, ctrl_next;

  always_comb begin
    // address and enable register together so the pins never skew apart
    pin_out_next = mem_addr;
    pin_oe_next = mem_addr_drive & ctrl_reg[rscc_pkg::CTRL_DRIVE_BIT];
    // pins must float in reset so the pull resistors set the straps
    if (sys_rst) begin
      pin_out_next = '0;
      pin_oe_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    pin_out_reg <= pin_out_next;
    pin_oe_reg <= pin_oe_next;
  end

  assign narrow_if_addr_pins_o = pin_out_reg;
  assign narrow_if_addr_pins_oe = pin_oe_reg;

  // ---------------- ahb-lite slave ----------------
  logic [31:0] cfg_word;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] addr_word;
  logic hresp_reg;
  logic hresp_next;
  logic hready_reg;
  logic hready_next;
  logic take;

  always_comb begin
    cfg_word = '0;
    cfg_word[rscc_pkg::CFG_ENDIAN_BIT] = endian_reg;
    cfg_word[rscc_pkg::CFG_BOOT_LSB +: 2] = boot_reg;
    cfg_word[rscc_pkg::CFG_WIDE_CLK_LSB +: 2] = wclk_reg;
    cfg_word[rscc_pkg::CFG_NARROW_CLK_LSB +: 2] = nclk_reg;
    cfg_word[rscc_pkg::CFG_AUTOINIT_BIT] = ainit_reg;
    cfg_word[rscc_pkg::CFG_CELL_PORT_BIT] = cell_reg;
    cfg_word[rscc_pkg::CFG_SERIAL_BIT] = serial_reg;
  end

  always_comb begin
    // bit 0 of a half-word address never reaches the pins
    addr_word = '0;
    addr_word[rscc_pkg::ADDR_MSB:rscc_pkg::ADDR_LSB] = pin_out_reg;
  end

  always_comb begin
    // no wait states and no error replies: every access is one data phase
    hresp_next = 1'b0;
    hready_next = 1'b1;
  end

  assign take = hsel & htrans[1] & hready;

  always_comb begin
    ctrl_next = ctrl_reg;
    wr_pend_next = take & hwrite;
    wr_addr_next = haddr[7:0];
    rdata_next = '0;
    if (wr_pend_reg && wr_addr_reg == rscc_pkg::CTRL_OFFSET) begin
      ctrl_next = {31'h0000_0000, hwdata[rscc_pkg::CTRL_DRIVE_BIT]};
    end
    // read data registered at the address phase: zero wait states
    // only the low byte of haddr decodes, so the map repeats every 256 bytes
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        rscc_pkg::CTRL_OFFSET: rdata_next = ctrl_next;
        rscc_pkg::CONFIG_OFFSET: rdata_next = cfg_word;
        rscc_pkg::ADDR_OFFSET: rdata_next = addr_word;
        default: rdata_next = '0;
      endcase
    end
    if (sys_rst) begin
      ctrl_next = rscc_pkg::CTRL_RESET;
      wr_pend_next = 1'b0;
      wr_addr_next = '0;
      rdata_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    ctrl_reg <= ctrl_next;
    wr_pend_reg <= wr_pend_next;
    wr_addr_reg <= wr_addr_next;
    rdata_reg <= rdata_next;
    hresp_reg <= hresp_next;
    hready_reg <= hready_next;
  end

  assign hrdata = rdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = hresp_reg;
endmodule // rscc_strap_loader

// >>> tb/rscc_asserts.sv
// checker: port-level properties of the strap loader
`timescale 1ns/100ps
module rscc_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // address path
  input wire logic [20:1] mem_addr,
  input wire logic mem_addr_drive,
  input wire logic [20:1] narrow_if_addr_pins_i,
  input wire logic [20:1] narrow_if_addr_pins_o,
  input wire logic narrow_if_addr_pins_oe,
  // captured configuration
  input wire logic little_endian,
  input wire logic [1:0] boot_mode,
  input wire logic [1:0] wide_if_clock_select,
  input wire logic [1:0] narrow_if_clock_select,
  input wire logic pci_eeprom_autoinit,
  input wire logic cell_port_enable,
  input wire logic serial_port_one_enable
);
  logic [20:1] s;
  logic [9:0] cfg;
  assign s = narrow_if_addr_pins_i;
  assign cfg = {serial_port_one_enable, cell_port_enable, pci_eeprom_autoinit,
    narrow_if_clock_select, wide_if_clock_select, boot_mode, little_endian};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // the bench holds straps steady across release, so the last pin sample
  // before release is the one that must have been captured
  a_oe_cause: assert property (
    narrow_if_addr_pins_oe |-> $past(mem_addr_drive))
    else $error("pins driven without a request");
  a_addr_out: assert property (
    narrow_if_addr_pins_oe |-> narrow_if_addr_pins_o == $past(mem_addr))
    else $error("pin address not last cycle address");
  a_oe_release: assert property (
    $fell(sys_rst) |-> !narrow_if_addr_pins_oe)
    else $error("pins driven at reset release");
  a_endian_pick: assert property (
    $fell(sys_rst) |-> little_endian == $past(s[20]))
    else $error("byte order differs from strap");
  a_boot_pick: assert property (
    $fell(sys_rst) |-> boot_mode == $past(s[19:18]))
    else $error("boot field differs from strap");
  a_clock_pick: assert property (
    $fell(sys_rst) |-> {wide_if_clock_select, narrow_if_clock_select} ==
      $past(s[17:14]))
    else $error("clock selects differ from strap");
  a_autoinit_pick: assert property (
    $fell(sys_rst) |-> pci_eeprom_autoinit == $past(s[13]))
    else $error("autoinit differs from strap");
  a_port_pick: assert property (
    $fell(sys_rst) |-> cell_port_enable == $past(s[11]) &&
      serial_port_one_enable != $past(s[11]))
    else $error("shared pin function wrong");
  a_cfg_frozen: assert property (
    !$past(sys_rst) |-> $stable(cfg))
    else $error("configuration moved outside reset");
endmodule // rscc_asserts

bind rscc_strap_loader rscc_asserts rscc_asserts_i (.*);

// >>> tb/rscc_strap_board.sv
// partner: board pull network on the address pins
`timescale 1ns/100ps
module rscc_strap_board (
  // pull levels chosen by the bench
  input wire logic [20:1] strap,
  // device pin side
  input wire logic [20:1] pin_o,
  input wire logic pin_oe,
  output logic [20:1] pin
);
  // pulls win only while the device lets go of the pins
  assign pin = pin_oe ? pin_o : strap;
endmodule // rscc_strap_board

// >>> tb/rscc_strap_loader_test.sv
// testbench: strap capture, pin drive and register checks
`timescale 1ns/100ps
module rscc_strap_loader_test;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [20:1] mem_addr = 20'h0_0000;
  logic mem_addr_drive = 1'h0;
  logic [20:1] strap = 20'hf_ffff;
  logic [20:1] pin, pin_o;
  logic pin_oe, hreadyout, hresp, ctl, little_endian, pci_eeprom_autoinit;
  logic cell_port_enable, serial_port_one_enable;
  logic [1:0] boot_mode, wide_if_clock_select, narrow_if_clock_select;
  logic [31:0] hrdata, r, tmp, seed, exp;
  int n_mismatch = 0;
  int checks_done = 0;
  wire logic [31:0] cfg = {22'h00_0000, serial_port_one_enable,
    cell_port_enable, pci_eeprom_autoinit, narrow_if_clock_select,
    wide_if_clock_select, boot_mode, little_endian};
  always #12.5 clk = ~clk;
  rscc_strap_loader rscc_strap_loader_i (.clk, .sys_rst, .hsel(1'h1),
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .mem_addr, .mem_addr_drive,
    .narrow_if_addr_pins_i(pin), .narrow_if_addr_pins_o(pin_o),
    .narrow_if_addr_pins_oe(pin_oe), .little_endian, .boot_mode,
    .wide_if_clock_select, .narrow_if_clock_select, .pci_eeprom_autoinit,
    .cell_port_enable, .serial_port_one_enable);
  rscc_strap_board rscc_strap_board_i (.strap, .pin_o, .pin_oe, .pin);
  function automatic logic [31:0] cfg_word(input logic [20:1] s);
    return {22'h00_0000, ~s[11], s[11], s[13], s[15:14], s[17:16],
      s[19:18], s[20]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // entered just after a rising edge; hready is sampled before edge updates
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge clk iff hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk iff hreadyout);
    q = hrdata;
    chk(hresp, 1'h0);
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    seed = 32'h4b1d_3f52;
    for (int i = 0; i < 8; i++) begin
      tmp = $random(seed);
      // every code of each two-bit field, reserved ones too
      strap <= {tmp[20], i[1:0], i[1:0], ~i[1:0], tmp[13:1]};
      sys_rst <= 1'h1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'h0;
      #1 chk(pin_oe, 1'h0);
      exp = cfg_word(strap);
      ctl = i[0];
      @(posedge clk);
      #1 chk(cfg, exp);
      @(posedge clk);
      strap <= ~strap;
      bus(1'h0, rscc_pkg::CTRL_OFFSET, exp, r);
      chk(r, rscc_pkg::CTRL_RESET);
      bus(1'h1, rscc_pkg::CTRL_OFFSET, {31'h0000_0000, ctl}, r);
      bus(1'h0, rscc_pkg::CTRL_OFFSET, exp, r);
      chk(r, {31'h0000_0000, ctl});
      bus(1'h1, rscc_pkg::CONFIG_OFFSET, 32'hffff_ffff, r);
      bus(1'h0, rscc_pkg::CONFIG_OFFSET, exp, r);
      chk(r, exp);
      bus(1'h0, 8'h0c, exp, r);
      chk(r, 32'h0000_0000);
      repeat (4) begin
        tmp = $random(seed);
        mem_addr <= tmp[20:1];
        mem_addr_drive <= tmp[0];
        @(posedge clk);
        #1 chk({pin_oe, pin_o}, {tmp[0] & ctl, tmp[20:1]});
        @(posedge clk);
      end
      bus(1'h0, rscc_pkg::ADDR_OFFSET, exp, r);
      chk(r, {11'h000, tmp[20:1], 1'h0});
    end
    summarize();
  end
  initial begin
    #(25 * 4000);
    n_mismatch++;
    summarize();
  end
endmodule // rscc_strap_loader_test
